// ===== design/dmc_defs.svh
// Purpose: constants for the external cache controller
// Assumes: included by bare name
// Notes:   offsets are Wishbone byte addresses
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_CTRL_OFS     8'h00
`define DMC_STAT_OFS     8'h04
`define DMC_CTRL_FLUSH   0
`define DMC_CTRL_NOCACHE 1
`define DMC_MEM_HI       31
`define DMC_MEM_LO       28
`define DMC_TAG_HI       31
`define DMC_TAG_LO       16
`define DMC_IDX_HI       15
`define DMC_IDX_LO       4
`define DMC_LW_HI        3
`define DMC_LW_LO        2
`define DMC_SIZ_LONG     2'h0
`define DMC_CLK_DIV      2
`endif

// ===== design/dmc_pkg.sv
// Purpose: types for the external cache controller
// Assumes: nothing
// Notes:   none
package dmc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FAULT,
		ST_MEMRD,
		ST_WRWAIT,
		ST_TERM,
		ST_ENDWAIT
	} dmc_state_t;

	typedef enum logic [1:0] {
		MP_IDLE,
		MP_REQ,
		MP_DROP
	} dmc_mph_t;
endpackage : dmc_pkg

// ===== design/dmc_ctrl.sv
// Purpose: direct-mapped external cache control, one clock
// Assumes: cpu pins are asynchronous; memory uses 4-phase req/ack
// Notes:   Wishbone classic slave for control and status
`include "dmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dmc_ctrl #(
	parameter int IDX_W  = 12,
	parameter int TAG_W  = 16,
	parameter int DATA_W = 14
) (
	input  wire logic              SYS_CLK_I,              // double-rate source
	input  wire logic              NRST_I,                 // async reset, low
	input  wire logic [7:0]        WB_ADR_I,               // wishbone address
	input  wire logic [31:0]       WB_DAT_I,               // wishbone write data
	output logic      [31:0]       WB_DAT_O,               // wishbone read data
	input  wire logic [3:0]        WB_SEL_I,               // byte selects
	input  wire logic              WB_WE_I,                // write
	input  wire logic              WB_CYC_I,               // cycle
	input  wire logic              WB_STB_I,               // strobe
	output logic                   WB_ACK_O,               // acknowledge
	input  wire logic [31:0]       CPU_ADDR_I,             // cpu address
	input  wire logic [2:0]        CPU_FC_I,               // function code
	input  wire logic [1:0]        CPU_SIZ_I,              // transfer size
	input  wire logic              CPU_RW_I,               // high = read
	input  wire logic              CPU_AS_N_I,             // address strobe
	input  wire logic [31:0]       CPU_DATA_I,             // cpu write data
	input  wire logic              CACHE_INHIBIT_N_I,      // cpu inhibit out
	input  wire logic              LOCKED_RMW_N_I,         // locked rmw
	input  wire logic              GRANT_ACK_N_I,          // bus grant ack
	input  wire logic              CACHE_DISABLE_JUMPER_I, // jumper fitted
	input  wire logic              FLUSH_N_I,              // flush request
	input  wire logic              MEM_ACK_I,              // memory ack
	output logic                   SYNC_TERM_N_O,          // sync termination
	output logic                   BUS_FAULT_N_O,          // bus error
	output logic                   HALT_N_O,               // halt
	output logic                   MEM_SELECT_N_O,         // memory space
	output logic                   CACHEABLE_N_O,          // cacheable space
	output logic                   TAG_WRITE_N_O,          // tag store write
	output logic [DATA_W-1:0]      CACHE_ADDR_O,           // data store index
	output logic                   MEM_REQ_O,              // memory request
	output logic                   MEM_WE_O,               // memory write
	output logic [31:0]            MEM_ADDR_O,             // memory address
	output logic [1:0]             MEM_SIZ_O,              // memory size
	output logic [31:0]            MEM_WDATA_O,            // memory write data
	output logic                   CPU_CLK_33_O            // divided cpu clock
);
	localparam int SW = 77;

	typedef struct packed {
		logic [SW-1:0]      s1;
		logic [SW-1:0]      s2;
		dmc_pkg::dmc_state_t state;
		dmc_pkg::dmc_mph_t  mph;
		logic               retry;
		logic               rd_upd;
		logic               pipe_full;
		logic               mem_we;
		logic [31:0]        mem_addr;
		logic [1:0]         mem_siz;
		logic [31:0]        mem_wdata;
		logic               term_n;
		logic               fault_n;
		logic               tag_we_n;
		logic               sel_n;
		logic               cach_n;
		logic [DATA_W-1:0]  cadr;
		logic               clk33;
		logic               nocache;
		logic               flush;
		logic               wb_ack;
		logic [31:0]        wb_dat;
		logic               mreq;
	} dmc_st_t;

	dmc_st_t                st_reg;
	dmc_st_t                st_next;
	logic [1:0]             rst_sync_reg;
	logic                   rst_n;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ------------------------------------------------------------
	// pin decode (second sync stage only)
	// ------------------------------------------------------------
	logic [31:0]            a;
	logic [2:0]             fc;
	logic [1:0]             siz;
	logic                   rd;
	logic                   as_n;
	logic [31:0]            wdat;
	logic                   inh_n;
	logic                   rmw_n;
	logic                   gack_n;
	logic                   jmp;
	logic                   flush_n;
	logic                   mack;
	logic                   mem_space;
	logic                   cacheable;
	logic [IDX_W-1:0]       idx;
	logic [1:0]             lw;
	logic [TAG_W-1:0]       tag_rd;
	logic [3:0]             v_rd;
	logic [3:0]             tag_slice_hit;
	logic                   tag_match;
	logic                   hit;
	logic                   cyc_go;
	logic                   mem_free;
	logic                   cycle_done_n;
	logic                   upd;
	logic [3:0]             v_new;

	assign {a, fc, siz, rd, as_n, wdat, inh_n, rmw_n, gack_n, jmp, flush_n, mack} = st_reg.s2;

	// space decode kept here so a new memory map is a one-line change
	assign mem_space = (a[`DMC_MEM_HI:`DMC_MEM_LO] == 4'h0)
		&& (fc == 3'h1 || fc == 3'h2 || fc == 3'h5 || fc == 3'h6);
	assign cacheable = mem_space && inh_n && rmw_n && gack_n
		&& !jmp && !st_reg.nocache;

	assign idx = a[`DMC_IDX_HI:`DMC_IDX_LO];
	assign lw  = a[`DMC_LW_HI:`DMC_LW_LO];

	// ------------------------------------------------------------
	// tag and validity stores
	// ------------------------------------------------------------
	logic [TAG_W-1:0]       tag_mem [2**IDX_W];
	logic [3:0]             valid_mem [2**IDX_W];

	assign tag_rd = tag_mem[idx];
	assign v_rd   = valid_mem[idx];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_slice
			assign tag_slice_hit[g] = tag_rd[g*4 +: 4]
				== a[`DMC_TAG_LO + g*4 +: 4];
		end
	endgenerate
	assign tag_match = &tag_slice_hit;
	assign hit = tag_match && v_rd[lw];

	// other bits survive only if the line already holds this tag
	assign v_new = (tag_match ? v_rd : 4'h0)
		| (4'h1 << lw);

	// flush wins over a same-cycle line update
	always_ff @(posedge SYS_CLK_I) begin
		if (!rst_n || st_reg.flush) begin
			for (int i = 0; i < 2**IDX_W; i++) begin
				valid_mem[i] <= 4'h0;
			end
		end else if (upd) begin
			valid_mem[idx] <= v_new;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (upd) begin
			tag_mem[idx] <= a[`DMC_TAG_HI:`DMC_TAG_LO];
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign mem_free = !st_reg.pipe_full && st_reg.mph == dmc_pkg::MP_IDLE;
	assign cyc_go = st_reg.state == dmc_pkg::ST_IDLE && !as_n && mem_space;
	assign upd = st_reg.state == dmc_pkg::ST_MEMRD && st_reg.mph == dmc_pkg::MP_REQ
		&& mack && st_reg.rd_upd;
	assign cycle_done_n = !(st_reg.state == dmc_pkg::ST_WRWAIT
		|| (st_reg.state == dmc_pkg::ST_MEMRD
		&& st_reg.mph == dmc_pkg::MP_REQ && mack));

	always_comb begin
		st_next = st_reg;
		st_next.s1 = {CPU_ADDR_I, CPU_FC_I, CPU_SIZ_I, CPU_RW_I, CPU_AS_N_I,
			CPU_DATA_I, CACHE_INHIBIT_N_I, LOCKED_RMW_N_I, GRANT_ACK_N_I,
			CACHE_DISABLE_JUMPER_I, FLUSH_N_I, MEM_ACK_I};
		st_next.s2 = st_reg.s1;
		st_next.clk33 = ~st_reg.clk33;
		st_next.sel_n = !(mem_space && !as_n);
		st_next.cach_n = !(cacheable && !as_n);
		st_next.cadr = a[`DMC_IDX_HI:`DMC_LW_LO];
		st_next.tag_we_n = !upd;
		st_next.flush = !flush_n;

		// memory handshake; the pipe empties on ack
		case (st_reg.mph)
			dmc_pkg::MP_REQ: begin
				if (mack) begin
					st_next.mph = dmc_pkg::MP_DROP;
					st_next.pipe_full = 1'b0;
				end
			end
			dmc_pkg::MP_DROP: begin
				if (!mack) begin
					st_next.mph = dmc_pkg::MP_IDLE;
				end
			end
			default: st_next.mph = dmc_pkg::MP_IDLE;
		endcase

		case (st_reg.state)
			dmc_pkg::ST_IDLE: begin
				if (cyc_go && rd) begin
					if (cacheable && !st_reg.retry) begin
						// hits ignore the pipe: it drains on its own
						if (hit) begin
							st_next.term_n = 1'b0;
							st_next.state = dmc_pkg::ST_TERM;
						end else begin
							st_next.fault_n = 1'b0;
							st_next.retry = 1'b1;
							st_next.state = dmc_pkg::ST_FAULT;
						end
					end else if (mem_free) begin
						st_next.mph = dmc_pkg::MP_REQ;
						st_next.mem_we = 1'b0;
						st_next.mem_addr = {a[31:2], 2'h0};
						st_next.mem_siz = `DMC_SIZ_LONG;
						st_next.rd_upd = cacheable;
						st_next.retry = 1'b0;
						st_next.state = dmc_pkg::ST_MEMRD;
					end
				end else if (cyc_go && mem_free) begin
					st_next.mph = dmc_pkg::MP_REQ;
					st_next.mem_we = 1'b1;
					st_next.mem_addr = a;
					st_next.mem_siz = siz;
					st_next.mem_wdata = wdat;
					st_next.pipe_full = 1'b1;
					st_next.state = dmc_pkg::ST_WRWAIT;
				end
			end
			dmc_pkg::ST_FAULT: begin
				if (as_n) begin
					st_next.fault_n = 1'b1;
					st_next.state = dmc_pkg::ST_IDLE;
				end
			end
			dmc_pkg::ST_MEMRD,
			dmc_pkg::ST_WRWAIT: begin
				if (!cycle_done_n) begin
					st_next.term_n = 1'b0;
					st_next.state = dmc_pkg::ST_TERM;
				end
			end
			dmc_pkg::ST_TERM: begin
				st_next.term_n = 1'b1;
				st_next.state = dmc_pkg::ST_ENDWAIT;
			end
			dmc_pkg::ST_ENDWAIT: begin
				if (as_n) begin
					st_next.state = dmc_pkg::ST_IDLE;
				end
			end
			default: st_next.state = dmc_pkg::ST_IDLE;
		endcase

		// request pin from its own flop, not from a state decode
		st_next.mreq = st_next.mph == dmc_pkg::MP_REQ;

		// register slave; unmapped reads return zero
		st_next.wb_ack = WB_CYC_I && WB_STB_I && !st_reg.wb_ack;
		st_next.wb_dat = 32'h0;
		if (WB_CYC_I && WB_STB_I && !st_reg.wb_ack) begin
			if (WB_ADR_I == `DMC_CTRL_OFS) begin
				if (WB_WE_I && WB_SEL_I[0]) begin
					st_next.nocache = WB_DAT_I[`DMC_CTRL_NOCACHE];
					st_next.flush = st_next.flush
						| WB_DAT_I[`DMC_CTRL_FLUSH];
				end
				st_next.wb_dat[`DMC_CTRL_NOCACHE] = st_reg.nocache;
			end else if (WB_ADR_I == `DMC_STAT_OFS) begin
				st_next.wb_dat[0] = st_reg.pipe_full;
				st_next.wb_dat[1] = st_reg.retry;
				st_next.wb_dat[2] = st_reg.state != dmc_pkg::ST_IDLE;
				st_next.wb_dat[3] = st_reg.mph != dmc_pkg::MP_IDLE;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.state <= dmc_pkg::ST_IDLE;
			st_reg.mph <= dmc_pkg::MP_IDLE;
			st_reg.term_n <= 1'b1;
			st_reg.fault_n <= 1'b1;
			st_reg.tag_we_n <= 1'b1;
			st_reg.sel_n <= 1'b1;
			st_reg.cach_n <= 1'b1;
			st_reg.s1 <= {SW{1'b1}};
			st_reg.s2 <= {SW{1'b1}};
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign SYNC_TERM_N_O  = st_reg.term_n;
	assign BUS_FAULT_N_O  = st_reg.fault_n;
	assign HALT_N_O       = st_reg.fault_n;
	assign MEM_SELECT_N_O = st_reg.sel_n;
	assign CACHEABLE_N_O  = st_reg.cach_n;
	assign TAG_WRITE_N_O  = st_reg.tag_we_n;
	assign CACHE_ADDR_O   = st_reg.cadr;
	assign MEM_REQ_O      = st_reg.mreq;
	assign MEM_WE_O       = st_reg.mem_we;
	assign MEM_ADDR_O     = st_reg.mem_addr;
	assign MEM_SIZ_O      = st_reg.mem_siz;
	assign MEM_WDATA_O    = st_reg.mem_wdata;
	assign CPU_CLK_33_O   = st_reg.clk33;
	assign WB_ACK_O       = st_reg.wb_ack;
	assign WB_DAT_O       = st_reg.wb_dat;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!rst_n);

	term_one_cyc_a: assert property (!SYNC_TERM_N_O |=> SYNC_TERM_N_O)
		else $error("sync term held too long");
	hit_term_a: assert property (cyc_go && rd && cacheable && !st_reg.retry && hit
		|=> !SYNC_TERM_N_O) else $error("read hit not terminated");
	miss_fault_a: assert property (cyc_go && rd && cacheable && !st_reg.retry && !hit
		|=> !BUS_FAULT_N_O && !HALT_N_O && SYNC_TERM_N_O) else $error("miss not retried");
	fault_rd_only_a: assert property ($fell(BUS_FAULT_N_O)
		|-> $past(rd) && $past(cacheable)) else $error("retry on write or noncacheable");
	wr_three_a: assert property (cyc_go && !rd && mem_free
		|-> ##2 !SYNC_TERM_N_O) else $error("write not done in one wait");
	pipe_stall_a: assert property (cyc_go && st_reg.pipe_full && !(rd && cacheable)
		|=> st_reg.state == dmc_pkg::ST_IDLE && SYNC_TERM_N_O) else $error("full pipe overrun");
	retry_late_a: assert property (cyc_go && rd && st_reg.retry
		|=> SYNC_TERM_N_O [*2]) else $error("early term on reissue");
	tag_we_only_a: assert property (!TAG_WRITE_N_O
		|-> $past(st_reg.rd_upd) && $past(st_reg.state) == dmc_pkg::ST_MEMRD)
		else $error("tag write outside retry");
	rd_align_a: assert property (MEM_REQ_O && !MEM_WE_O
		|-> MEM_ADDR_O[1:0] == 2'h0 && MEM_SIZ_O == `DMC_SIZ_LONG) else $error("unaligned read");

	hit_c: cover property (cyc_go && rd && hit && cacheable);
	miss_c: cover property (!BUS_FAULT_N_O ##[1:40] upd);
	wr_c: cover property (cyc_go && !rd ##[1:40] !SYNC_TERM_N_O);
	hit_drain_c: cover property (st_reg.pipe_full && !SYNC_TERM_N_O);
endmodule : dmc_ctrl

`default_nettype wire

// ===== tb/dmc_mem_model.sv
// Purpose: memory side of the cache controller's request port
// Assumes: four-phase request and acknowledge, one clock
// Notes:   answer delay is set by the bench per access
`timescale 1ns/1ps
`default_nettype none

module dmc_mem_model (
	input  wire logic       clk_i,   // system clock
	input  wire logic       rst_n_i, // reset, low
	input  wire logic       req_i,   // memory request
	input  wire logic [7:0] dly_i,   // cycles before answering
	output logic            ack_o,   // memory acknowledge
	output logic [15:0]     acks_o   // answers given so far
);
	logic [7:0] wait_cnt;

	// --------
	// acknowledge
	// --------
	// ack stays up until the request drops, so a slow synchroniser never misses it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o    <= 1'h0;
			acks_o   <= 16'h0000;
			wait_cnt <= 8'h00;
		end else if (ack_o) begin
			ack_o <= req_i;
		end else if (req_i && wait_cnt >= dly_i) begin
			ack_o    <= 1'h1;
			acks_o   <= acks_o + 16'h0001;
			wait_cnt <= 8'h00;
		end else if (req_i) begin
			wait_cnt <= wait_cnt + 8'h01;
		end
	end
endmodule : dmc_mem_model

`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for the external cache controller
// Assumes: bench plays the processor; dmc_mem_model answers memory
// Notes:   hits are predicted by a reference tag and validity model
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk, nrst, wb_we, wb_cyc, wb_stb, wb_ack, cpu_rw, as_n, inh_n, rmw_n, gack_n, jumper;
	logic        flush_n, mem_ack, sync_term_n, bus_fault_n, halt_n, mem_sel_n, cach_n, tag_write_n;
	logic        mem_req, mem_we, cpu_clk, ms, cs, hs, run, wb_nc, clk_prev;
	logic [7:0]  wb_adr, mdly;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat, wb_rdat, cpu_addr, cpu_data, mem_addr, mem_wdata, q, a;
	logic [2:0]  cpu_fc, fc_v;
	logic [1:0]  cpu_siz, mem_siz, siz_v;
	logic [13:0] cache_addr, ca;
	logic [15:0] acks, a0;
	logic [65:0] mcap [2];
	logic [15:0] tag_ref [logic [11:0]];
	logic [3:0]  val_ref [logic [11:0]];
	logic [2:0]  fcs [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
	logic [31:0] seq [6] = '{32'h0001_0015, 32'h0001_0014, 32'h0001_0018, 32'h0001_0014,
		32'h0002_0014, 32'h0001_0018};
	int          failures = 0, samples_checked = 0, cycles = 0, res, n, tagw_cnt = 0;

	dmc_ctrl i_dmc_ctrl (
		.SYS_CLK_I(clk), .NRST_I(nrst), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rdat),
		.WB_SEL_I(wb_sel), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack),
		.CPU_ADDR_I(cpu_addr), .CPU_FC_I(cpu_fc), .CPU_SIZ_I(cpu_siz), .CPU_RW_I(cpu_rw),
		.CPU_AS_N_I(as_n), .CPU_DATA_I(cpu_data), .CACHE_INHIBIT_N_I(inh_n), .LOCKED_RMW_N_I(rmw_n),
		.GRANT_ACK_N_I(gack_n), .CACHE_DISABLE_JUMPER_I(jumper), .FLUSH_N_I(flush_n),
		.MEM_ACK_I(mem_ack), .SYNC_TERM_N_O(sync_term_n), .BUS_FAULT_N_O(bus_fault_n),
		.HALT_N_O(halt_n), .MEM_SELECT_N_O(mem_sel_n), .CACHEABLE_N_O(cach_n),
		.TAG_WRITE_N_O(tag_write_n), .CACHE_ADDR_O(cache_addr), .MEM_REQ_O(mem_req),
		.MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_SIZ_O(mem_siz), .MEM_WDATA_O(mem_wdata),
		.CPU_CLK_33_O(cpu_clk)
	);
	dmc_mem_model i_dmc_mem_model (
		.clk_i(clk), .rst_n_i(nrst), .req_i(mem_req), .dly_i(mdly), .ack_o(mem_ack), .acks_o(acks)
	);

	always #5 clk = ~clk;

	// --------
	// bench helpers
	// --------
	task automatic wrap_up();
		$display("samples_checked=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	always @(negedge clk) begin
		cycles++;
		if (run) chk(cpu_clk, !clk_prev);
		clk_prev = cpu_clk;
		if (cycles == 30000) begin
			failures++;
			wrap_up();
		end
	end

	// last request of each direction, as memory saw it
	always @(negedge clk) begin
		if (tag_write_n === 1'h0) tagw_cnt++;
		if (mem_req === 1'h1) mcap[mem_we] = {mem_addr, mem_siz, mem_wdata};
	end

	function automatic logic hit_exp(input logic [31:0] ad);
		logic [11:0] i;
		i = ad[15:4];
		return val_ref.exists(i) && tag_ref[i] == ad[31:16] && val_ref[i][ad[3:2]];
	endfunction : hit_exp

	function automatic void fill(input logic [31:0] ad);
		logic [11:0] i;
		i = ad[15:4];
		if (!(val_ref.exists(i) && tag_ref[i] == ad[31:16]))
			val_ref[i] = 4'h0;
		val_ref[i][ad[3:2]] = 1'h1;
		tag_ref[i] = ad[31:16];
	endfunction : fill

	task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		{wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <= {2'h3, we, 4'hF, ad, d};
		// ends on wb_ack; only the bench timeout ends it if no ack comes
		do begin
			@(posedge clk);
		end while (wb_ack !== 1'h1);
		q = wb_rdat;
		{wb_cyc, wb_stb} <= 2'h0;
		@(posedge clk);
	endtask : wb

	task automatic flush_pin();
		@(posedge clk);
		flush_n <= 1'h0;
		repeat (4) @(posedge clk);
		flush_n <= 1'h1;
		repeat (3) @(posedge clk);
		val_ref.delete();
	endtask : flush_pin

	// processor cycle; res 1 = terminated, 2 = fault, 0 = no answer
	task automatic cyc(input logic [31:0] ad, input logic rd, input logic [2:0] why, input int lim);
		res = 0;
		n = 0;
		@(posedge clk);
		{cpu_addr, cpu_data, cpu_rw, cpu_siz, cpu_fc} <= {ad, ~ad, rd, siz_v, fc_v};
		{inh_n, rmw_n, gack_n, jumper} <= {why != 3'h1, why != 3'h2, why != 3'h3, why == 3'h4};
		as_n <= 1'h0;
		while (res == 0 && n < lim) begin
			@(negedge clk);
			n++;
			res = (sync_term_n === 1'h0) ? 1 : (bus_fault_n === 1'h0) ? 2 : 0;
		end
		{ms, cs, ca, hs} = {mem_sel_n, cach_n, cache_addr, halt_n};
		@(posedge clk);
		as_n <= 1'h1;
		for (int k = 0; k < 20 && bus_fault_n !== 1'h1; k++) @(negedge clk);
		repeat (2) @(posedge clk); // two idle clocks before any reissue
	endtask : cyc

	task automatic access(input logic [31:0] ad, input logic rd, input logic [2:0] why);
		logic c, miss;
		int   t0;
		c    = why == 3'h0 && !wb_nc;
		miss = rd && c && !hit_exp(ad);
		t0   = tagw_cnt;
		a0   = acks;
		mcap = '{default: '1};
		cyc(ad, rd, why, 200);
		chk(ms, 1'h0);
		chk(cs, !c);
		if (miss) begin
			chk(res, 2);
			chk(hs, 1'h0);
			cyc(ad, rd, why, 200);
			fill(ad);
		end else if (rd && c) begin
			chk(n <= 6, 1'h1);
			chk(ca, ad[15:2]);
		end
		chk(res, 1);
		chk(tagw_cnt - t0, miss);
		if (rd && (miss || !c)) begin
			chk(mcap[0][65:32], {ad[31:2], 4'h0});
			chk(acks != a0, 1'h1);
		end
		if (!rd) chk({mcap[1][65:34], mcap[1][31:0]}, {ad, ~ad});
	endtask : access

	// --------
	// sequence
	// --------
	initial begin
		{clk, nrst, wb_we, wb_cyc, wb_stb, jumper, run, wb_nc, clk_prev} = '0;
		{cpu_rw, as_n, inh_n, rmw_n, gack_n, flush_n} = '1;
		{wb_adr, wb_sel, wb_dat, cpu_addr, cpu_data, mdly, cpu_siz, siz_v} = '0;
		{cpu_fc, fc_v} = 6'h09;
		void'($urandom(32'h75B874B2));
		repeat (16) @(posedge clk);
		chk({sync_term_n, bus_fault_n, halt_n, tag_write_n, mem_req}, 5'h1E);
		nrst <= 1'h1;
		repeat (6) @(posedge clk);
		run = 1'h1;
		wb(1'h1, 8'h00, 32'h0000_0002);
		wb(1'h0, 8'h00, 32'h0000_0000);
		chk(q[1], 1'h1);
		wb_nc = 1'h1;
		access(32'h0000_0100, 1'h1, 3'h0);
		wb(1'h1, 8'h00, 32'h0000_0000);
		wb_nc = 1'h0;
		wb(1'h0, 8'h04, 32'h0000_0000);
		chk(q[0], 1'h0);
		wb(1'h1, 8'h10, 32'hFFFF_FFFF);
		wb(1'h0, 8'h10, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		// cpu space and addresses above the memory range get no answer
		fc_v = 3'h7;
		cyc(32'h0000_0100, 1'h1, 3'h0, 30);
		chk({res[1:0], ms}, 3'h1);
		fc_v = 3'h1;
		cyc(32'h1000_0100, 1'h1, 3'h0, 30);
		chk({res[1:0], ms}, 3'h1);
		for (int w = 1; w < 5; w++) begin
			access(32'h0000_0200, 1'h1, 3'(w));
			access(32'h0000_0204, 1'h0, 3'(w));
		end
		siz_v = 2'h1;
		foreach (seq[i]) access(seq[i], 1'h1, 3'h0);
		siz_v = 2'h0;
		// slow memory: a hit is served while the first write drains, the second write waits
		mdly = 8'h28;
		access(32'h0003_0040, 1'h0, 3'h0);
		chk(n <= 7, 1'h1);
		access(32'h0001_0018, 1'h1, 3'h0);
		access(32'h0003_0080, 1'h0, 3'h0);
		chk(n > 15, 1'h1);
		mdly = 8'h02;
		flush_pin();
		access(32'h0001_0018, 1'h1, 3'h0);
		wb(1'h1, 8'h00, 32'h0000_0001);
		val_ref.delete();
		access(32'h0001_0018, 1'h1, 3'h0);
		repeat (150) begin
			mdly  = 8'($urandom_range(0, 6));
			siz_v = 2'($urandom);
			fc_v  = fcs[$urandom_range(0, 3)];
			a     = {12'h000, 4'($urandom_range(1, 2)), 10'h000, 6'($urandom)};
			if ($urandom_range(0, 24) == 0) flush_pin();
			access(a, $urandom_range(0, 2) != 0, ($urandom_range(0, 9) < 7) ? 3'h0 : 3'($urandom_range(1, 4)));
		end
		wrap_up();
	end
endmodule : tb

`default_nettype wire
